// ---- verilog/tic_pkg.sv ----
// Package: register map, field layout and direction encodings for capture cfg
package tic_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [31:0] RESET_VAL = 32'h0000_0000;
   localparam logic [31:0] MODE_MASK = 32'h0000_ffff;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0307;

   // ------------------------------------------------------------
   // Mode register field positions
   // ------------------------------------------------------------
   localparam int CH1_DIR_LSB = 0;
   localparam int CH1_PSC_LSB = 2;
   localparam int CH1_FILT_LSB = 4;
   localparam int CH2_DIR_LSB = 8;
   localparam int CH2_PSC_LSB = 10;
   localparam int CH2_FILT_LSB = 12;

   // ------------------------------------------------------------
   // Control and status field positions
   // ------------------------------------------------------------
   localparam int CTRL_EN1_BIT = 0;
   localparam int CTRL_EN2_BIT = 1;
   localparam int CTRL_TRG_BIT = 2;
   localparam int CTRL_CKD_LSB = 8;
   localparam int STAT_FILT_LSB = 0;
   localparam int STAT_PSC1_LSB = 4;
   localparam int STAT_PSC2_LSB = 8;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0] DIR_OUTPUT = 2'h0;
   localparam logic [1:0] DIR_OWN = 2'h1;
   localparam logic [1:0] DIR_OTHER = 2'h2;
   localparam logic [1:0] DIR_TRIG = 2'h3;

   typedef struct packed {
      logic kern;
      logic [2:0] div_log2;
      logic [3:0] n;
   } tic_filt_cfg_s;

   typedef struct packed {
      logic [1:0] dir;
      logic [1:0] psc;
      logic [3:0] filt;
   } tic_chan_cfg_s;

endpackage

// ---- verilog/tic_capture_cfg.sv ----
// Two-channel input capture configuration: filter, routing, prescaler
//
// How it works
// - Ch2 direction: 00 output, 01 input 2, 10 input 1, 11 trigger.
// - Ch2 direction writes take effect only while ch2 is disabled.
// - Trigger routing works only when internal trigger source is chosen.
// - Ch1 direction bits 1:0: 00 output, 01 input 1, 10 input 2, 11 trigger.
// - Ch1 direction writes take effect only while ch1 is disabled.
// - Ch1 filter passes a level after N equal consecutive samples.
// - Code 0 no filter at sampling rate; 1..3 kernel rate, N 2,4,8.
// - Codes 4,5 sample rate/2 N 6,8; code 8 rate/8 N 8.
// - Codes 10..12 rate/16 N 5,6,8; 13,14 rate/32 N 5,6.
// - Prescaler captures every 1, 2, 4 or 8 detected edges.
// - Prescaler event count is held cleared while channel disabled.
// - Ch2 filter 15:12, prescaler 11:10 reset zero; 31:16 read zero.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps

module tic_capture_cfg (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_input_1,
   input wire logic timer_input_2,
   input wire logic internal_trigger_input,
   output logic ch1_filtered,
   output logic ch2_filtered,
   output logic ch1_capture_pulse,
   output logic ch2_capture_pulse
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic tic_pkg::tic_filt_cfg_s filt_cfg(input logic [3:0] c);
      tic_pkg::tic_filt_cfg_s r;
      r.kern = 1'b0;
      r.div_log2 = 3'h0;
      r.n = 4'h1;
      unique case (c)
         4'h0: r.n = 4'h1;
         4'h1: begin r.kern = 1'b1; r.n = 4'h2; end
         4'h2: begin r.kern = 1'b1; r.n = 4'h4; end
         4'h3: begin r.kern = 1'b1; r.n = 4'h8; end
         4'h4: begin r.div_log2 = 3'h1; r.n = 4'h6; end
         4'h5: begin r.div_log2 = 3'h1; r.n = 4'h8; end
         4'h6: begin r.div_log2 = 3'h2; r.n = 4'h6; end
         4'h7: begin r.div_log2 = 3'h2; r.n = 4'h8; end
         4'h8: begin r.div_log2 = 3'h3; r.n = 4'h8; end
         4'h9: begin r.div_log2 = 3'h3; r.n = 4'h6; end
         4'ha: begin r.div_log2 = 3'h4; r.n = 4'h5; end
         4'hb: begin r.div_log2 = 3'h4; r.n = 4'h6; end
         4'hc: begin r.div_log2 = 3'h4; r.n = 4'h8; end
         4'hd: begin r.div_log2 = 3'h5; r.n = 4'h5; end
         4'he: begin r.div_log2 = 3'h5; r.n = 4'h6; end
         4'hf: begin r.div_log2 = 3'h5; r.n = 4'h8; end
      endcase
      return r;
   endfunction

   // Low-bit mask of k ones (value 2**k - 1), used for divide decisions
   function automatic logic [4:0] low_mask(input logic [2:0] k);
      return 5'((6'h01 << k) - 6'h01);
   endfunction

   // Source routing; own/other differ between the two channels
   function automatic logic route(input logic [1:0] dir, input logic own,
                                  input logic other, input logic trg,
                                  input logic trg_ok);
      logic r;
      r = 1'b0;
      unique case (dir)
         tic_pkg::DIR_OUTPUT: r = 1'b0;
         tic_pkg::DIR_OWN: r = own;
         tic_pkg::DIR_OTHER: r = other;
         tic_pkg::DIR_TRIG: r = trg & trg_ok;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [15:0] mode_q;
   logic [9:0] ctrl_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [1:0] ti_meta_q;
   logic [1:0] ti_sync_q;
   logic [1:0] filt_q;
   logic [3:0] fcnt_q [2];
   logic [1:0] dts_pre_q;
   logic [4:0] dts_cnt_q;
   logic [1:0] prev_q;
   logic [2:0] psc_cnt_q [2];
   logic [1:0] cap_q;

   tic_pkg::tic_chan_cfg_s ch_cfg [2];
   tic_pkg::tic_filt_cfg_s fcfg [2];
   logic [1:0] en;
   logic trg_ok;
   logic dts_tick;
   logic [4:0] dts_mask;
   logic [4:0] psc_mask [2];
   logic [1:0] samp_en;
   logic [1:0] chan_in;
   logic [1:0] edge_det;
   logic acc_wr;
   logic setup;
   logic mapped;

   assign ch_cfg[0] = {mode_q[tic_pkg::CH1_DIR_LSB +: 2],
                       mode_q[tic_pkg::CH1_PSC_LSB +: 2],
                       mode_q[tic_pkg::CH1_FILT_LSB +: 4]};
   assign ch_cfg[1] = {mode_q[tic_pkg::CH2_DIR_LSB +: 2],
                       mode_q[tic_pkg::CH2_PSC_LSB +: 2],
                       mode_q[tic_pkg::CH2_FILT_LSB +: 4]};
   assign en = {ctrl_q[tic_pkg::CTRL_EN2_BIT], ctrl_q[tic_pkg::CTRL_EN1_BIT]};
   assign trg_ok = ctrl_q[tic_pkg::CTRL_TRG_BIT];

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // Zero-wait: pready rises in the access cycle from a setup-time flop
   assign setup = psel & ~penable;
   assign acc_wr = psel & penable & pready_q & pwrite;
   assign mapped = (paddr == tic_pkg::MODE_OFS) ||
                   (paddr == tic_pkg::CTRL_OFS) ||
                   (paddr == tic_pkg::STAT_OFS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= tic_pkg::RESET_VAL;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~mapped;
         prdata_q <= tic_pkg::RESET_VAL;
         if (setup && !pwrite) begin
            unique case (paddr)
               tic_pkg::MODE_OFS: prdata_q <= {16'h0000, mode_q};
               tic_pkg::CTRL_OFS: prdata_q <= {22'h0, ctrl_q};
               tic_pkg::STAT_OFS: prdata_q <= {21'h0, psc_cnt_q[1], 1'b0,
                                               psc_cnt_q[0], 2'h0, filt_q};
               default: prdata_q <= tic_pkg::RESET_VAL;
            endcase
         end
      end
   end

   // Direction fields are frozen while their channel is enabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= tic_pkg::RESET_VAL[15:0];
      end else if (acc_wr && paddr == tic_pkg::MODE_OFS) begin
         mode_q[15:10] <= pwdata[15:10];
         mode_q[7:2] <= pwdata[7:2];
         if (!en[1]) begin
            mode_q[tic_pkg::CH2_DIR_LSB +: 2] <=
               pwdata[tic_pkg::CH2_DIR_LSB +: 2];
         end
         if (!en[0]) begin
            mode_q[tic_pkg::CH1_DIR_LSB +: 2] <=
               pwdata[tic_pkg::CH1_DIR_LSB +: 2];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= tic_pkg::RESET_VAL[9:0];
      end else if (acc_wr && paddr == tic_pkg::CTRL_OFS) begin
         ctrl_q <= pwdata[9:0] & tic_pkg::CTRL_MASK[9:0];
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;

   // ------------------------------------------------------------
   // Pin synchronisers and sampling clock
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ti_meta_q <= 2'h0;
         ti_sync_q <= 2'h0;
      end else begin
         ti_meta_q <= {timer_input_2, timer_input_1};
         ti_sync_q <= ti_meta_q;
      end
   end

   // Sampling clock is the kernel clock divided by 1, 2 or 4
   assign dts_mask = low_mask({1'b0, ctrl_q[tic_pkg::CTRL_CKD_LSB +: 2]});
   assign dts_tick = (dts_pre_q & dts_mask[1:0]) == 2'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dts_pre_q <= 2'h0;
         dts_cnt_q <= 5'h00;
      end else begin
         dts_pre_q <= dts_pre_q + 2'h1;
         if (dts_tick) begin
            dts_cnt_q <= dts_cnt_q + 5'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Digital filters: input 1 by ch1 code, input 2 by ch2 code
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         fcfg[i] = filt_cfg(ch_cfg[i].filt);
         psc_mask[i] = low_mask({1'b0, ch_cfg[i].psc});
         samp_en[i] = fcfg[i].kern | (dts_tick &&
            (dts_cnt_q & low_mask(fcfg[i].div_log2)) == 5'h00);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_q <= 2'h0;
         fcnt_q[0] <= 4'h0;
         fcnt_q[1] <= 4'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (samp_en[i]) begin
               if (ti_sync_q[i] == filt_q[i]) begin
                  fcnt_q[i] <= 4'h0;
               end else if (fcnt_q[i] + 4'h1 >= fcfg[i].n) begin
                  filt_q[i] <= ti_sync_q[i];
                  fcnt_q[i] <= 4'h0;
               end else begin
                  fcnt_q[i] <= fcnt_q[i] + 4'h1;
               end
            end
         end
      end
   end

   assign ch1_filtered = filt_q[0];
   assign ch2_filtered = filt_q[1];

   // ------------------------------------------------------------
   // Routing, edge detect and capture prescaler
   // ------------------------------------------------------------
   assign chan_in[0] = route(ch_cfg[0].dir, filt_q[0], filt_q[1],
                             internal_trigger_input, trg_ok);
   assign chan_in[1] = route(ch_cfg[1].dir, filt_q[1], filt_q[0],
                             internal_trigger_input, trg_ok);
   // Rising edges only; no polarity control lives in this block
   assign edge_det = chan_in & ~prev_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 2'h0;
      end else begin
         prev_q <= chan_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psc_cnt_q[0] <= 3'h0;
         psc_cnt_q[1] <= 3'h0;
         cap_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            cap_q[i] <= 1'b0;
            if (!en[i]) begin
               psc_cnt_q[i] <= 3'h0;
            end else if (edge_det[i]) begin
               if (psc_cnt_q[i] == psc_mask[i][2:0]) begin
                  psc_cnt_q[i] <= 3'h0;
                  cap_q[i] <= 1'b1;
               end else begin
                  psc_cnt_q[i] <= psc_cnt_q[i] + 3'h1;
               end
            end
         end
      end
   end

   assign ch1_capture_pulse = cap_q[0];
   assign ch2_capture_pulse = cap_q[1];

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ch2_dir_lock_a: assert property (
      acc_wr && paddr == tic_pkg::MODE_OFS && en[1]
      |=> $stable(mode_q[tic_pkg::CH2_DIR_LSB +: 2]))
      else $error("ch2 direction changed while enabled");

   ch1_dir_lock_a: assert property (
      acc_wr && paddr == tic_pkg::MODE_OFS && en[0]
      |=> $stable(mode_q[tic_pkg::CH1_DIR_LSB +: 2]))
      else $error("ch1 direction changed while enabled");

   ch1_dir_write_a: assert property (
      acc_wr && paddr == tic_pkg::MODE_OFS && !en[0]
      |=> mode_q[1:0] == $past(pwdata[1:0]))
      else $error("ch1 direction write lost");

   ch1_route_a: assert property (
      ch_cfg[0].dir == tic_pkg::DIR_OTHER |-> chan_in[0] == filt_q[1])
      else $error("ch1 not routed from input 2");

   ch2_route_a: assert property (
      ch_cfg[1].dir == tic_pkg::DIR_OWN |-> chan_in[1] == filt_q[1])
      else $error("ch2 not routed from input 2");

   trig_gate_a: assert property (
      !trg_ok |-> !(ch_cfg[0].dir == tic_pkg::DIR_TRIG && chan_in[0]))
      else $error("trigger routed without trigger source");

   psc_clear_a: assert property (
      !en[0] |=> psc_cnt_q[0] == 3'h0 && !cap_q[0])
      else $error("ch1 prescaler not cleared");

   psc_div2_a: assert property (
      en[0] && ch_cfg[0].psc == 2'h1 && edge_det[0] && psc_cnt_q[0] == 3'h0
      |=> !cap_q[0] && psc_cnt_q[0] == 3'h1)
      else $error("ch1 divide by two captured early");

   filt_kern2_a: assert property (
      ch_cfg[0].filt == 4'h1 && ti_sync_q[0] != filt_q[0] && fcnt_q[0] == 4'h0
      ##1 ch_cfg[0].filt == 4'h1 && ti_sync_q[0] != filt_q[0]
      |=> filt_q[0] == $past(ti_sync_q[0]))
      else $error("ch1 two-sample filter did not pass");

   filt_hold_a: assert property (
      samp_en[0] && ti_sync_q[0] != filt_q[0] &&
      fcnt_q[0] + 4'h1 < fcfg[0].n |=> $stable(filt_q[0]))
      else $error("ch1 filter passed too early");

   rsvd_zero_a: assert property (
      pready_q && !pwrite && paddr == tic_pkg::MODE_OFS
      |-> prdata_q[31:16] == 16'h0000)
      else $error("reserved mode bits not zero");

   cap_ch1_c: cover property (cap_q[0]);
   cap_ch2_trig_c: cover property (
      cap_q[1] && ch_cfg[1].dir == tic_pkg::DIR_TRIG);
   filt_slow_c: cover property (
      $changed(filt_q[0]) && ch_cfg[0].filt == 4'hd);

endmodule

// ---- tb/tb_tic_capture_cfg.sv ----
// Self-checking bench for the two-channel capture configuration block
`timescale 1ns/100ps

module tb_tic_capture_cfg;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic in1, in2, trg, f1, f2, cap1, cap2;
   int num_errors = 0;
   int n_checks = 0;
   int cnt1 = 0;
   int cnt2 = 0;
   int fc[12] = '{0, 1, 2, 3, 4, 5, 8, 10, 11, 12, 13, 14};
   int fd[12] = '{1, 1, 1, 1, 2, 2, 8, 16, 16, 16, 32, 32};
   int fn[12] = '{1, 2, 4, 8, 6, 8, 8, 5, 6, 8, 5, 6};

   tic_capture_cfg dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_input_1(in1), .timer_input_2(in2),
      .internal_trigger_input(trg), .ch1_filtered(f1), .ch2_filtered(f2),
      .ch1_capture_pulse(cap1), .ch2_capture_pulse(cap2));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(posedge pclk) if (cap1 === 1'b1) cnt1++;
   always @(posedge pclk) if (cap2 === 1'b1) cnt2++;

   // ------------------------------------------------------------
   // Shared helpers
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (pready !== 1'b1) num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] mw(logic [1:0] d1, logic [1:0] p1,
      logic [3:0] f1c, logic [1:0] d2, logic [1:0] p2, logic [3:0] f2c);
      return {16'h0, f2c, p2, d2, f1c, p1, d1};
   endfunction

   // Disable first so the direction fields accept the new value
   task automatic cfg(input logic [31:0] m, input logic [31:0] c);
      apb(1'b1, tic_pkg::CTRL_OFS, 32'h0);
      apb(1'b1, tic_pkg::MODE_OFS, m);
      apb(1'b1, tic_pkg::CTRL_OFS, c);
   endtask

   task automatic pulse(input int p, input int w, input int gap);
      @(posedge pclk);
      if (p == 0) in1 <= 1'b1;
      else if (p == 1) in2 <= 1'b1;
      else trg <= 1'b1;
      repeat (w) @(posedge pclk);
      in1 <= 1'b0;
      in2 <= 1'b0;
      trg <= 1'b0;
      repeat (gap) @(posedge pclk);
   endtask

   function automatic int cnt(input int ch);
      return (ch == 0) ? cnt1 : cnt2;
   endfunction

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, tic_pkg::MODE_OFS, 32'h0);
      check(rd, 32'h0);
      apb(1'b1, tic_pkg::MODE_OFS, 32'hffff_ffff);
      apb(1'b0, tic_pkg::MODE_OFS, 32'h0);
      check(rd, 32'h0000_ffff);
      apb(1'b0, 8'h0c, 32'h0);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      apb(1'b1, tic_pkg::MODE_OFS, 32'h0);
   endtask

   task automatic t_lock();
      cfg(mw(2'h1, 2'h0, 4'h0, 2'h1, 2'h0, 4'h0), 32'h3);
      apb(1'b1, tic_pkg::MODE_OFS, mw(2'h2, 2'h1, 4'h3, 2'h2, 2'h1, 4'h3));
      apb(1'b0, tic_pkg::MODE_OFS, 32'h0);
      check(rd, mw(2'h1, 2'h1, 4'h3, 2'h1, 2'h1, 4'h3));
      apb(1'b1, tic_pkg::CTRL_OFS, 32'h1);
      apb(1'b1, tic_pkg::MODE_OFS, mw(2'h2, 2'h0, 4'h0, 2'h2, 2'h0, 4'h0));
      apb(1'b0, tic_pkg::MODE_OFS, 32'h0);
      check(rd, mw(2'h1, 2'h0, 4'h0, 2'h2, 2'h0, 4'h0));
   endtask

   task automatic t_route();
      int c1, c2, e1, e2;
      for (int d = 0; d < 4; d++) begin
         for (int tb = 0; tb < 2; tb++) begin
            cfg(mw(2'(d), 2'h0, 4'h0, 2'(d), 2'h0, 4'h0), 32'(3 + 4 * tb));
            for (int p = 0; p < 3; p++) begin
               c1 = cnt1;
               c2 = cnt2;
               pulse(p, 4, 12);
               e1 = (d == 1 && p == 0) || (d == 2 && p == 1);
               e2 = (d == 1 && p == 1) || (d == 2 && p == 0);
               if (d == 3 && p == 2 && tb == 1) e1 = 1;
               if (d == 3 && p == 2 && tb == 1) e2 = 1;
               check(32'(cnt1 - c1), 32'(e1));
               check(32'(cnt2 - c2), 32'(e2));
            end
         end
      end
   endtask

   // Too short a pulse yields at most N-1 samples; a long one at least N
   task automatic t_filter();
      int c, g;
      for (int ch = 0; ch < 2; ch++) begin
         for (int i = 0; i < 12; i++) begin
            g = fd[i] * (fn[i] + 2) + 8;
            if (ch == 0) cfg(mw(2'h1, 2'h0, 4'(fc[i]), 2'h0, 2'h0, 4'h0), 1);
            else cfg(mw(2'h0, 2'h0, 4'h0, 2'h1, 2'h0, 4'(fc[i])), 2);
            c = cnt(ch);
            if (fn[i] > 1) pulse(ch, fd[i] * (fn[i] - 1), g);
            check(32'(cnt(ch) - c), 32'h0);
            pulse(ch, fd[i] * (fn[i] + 1), g);
            check(32'(cnt(ch) - c), 32'h1);
            check({31'h0, (ch == 0) ? f1 : f2}, 32'h0);
         end
      end
      // Sampling clock at kernel/2: code 4 samples every 4 cycles, N 6
      cfg(mw(2'h1, 2'h0, 4'h4, 2'h0, 2'h0, 4'h0), 32'h101);
      c = cnt1;
      pulse(0, 20, 40);
      check(32'(cnt1 - c), 32'h0);
      pulse(0, 28, 40);
      check(32'(cnt1 - c), 32'h1);
   endtask

   task automatic t_psc();
      int c;
      for (int ch = 0; ch < 2; ch++) begin
         for (int p = 0; p < 4; p++) begin
            if (ch == 0) cfg(mw(2'h1, 2'(p), 4'h0, 2'h0, 2'h0, 4'h0), 1);
            else cfg(mw(2'h0, 2'h0, 4'h0, 2'h1, 2'(p), 4'h0), 2);
            c = cnt(ch);
            repeat (8) pulse(ch, 3, 6);
            check(32'(cnt(ch) - c), 32'(8 >> p));
         end
      end
      cfg(mw(2'h1, 2'h3, 4'h0, 2'h0, 2'h0, 4'h0), 1);
      repeat (3) pulse(0, 3, 6);
      apb(1'b0, tic_pkg::STAT_OFS, 32'h0);
      check(32'(rd[tic_pkg::STAT_PSC1_LSB +: 3]), 32'h3);
      apb(1'b1, tic_pkg::CTRL_OFS, 32'h0);
      apb(1'b0, tic_pkg::STAT_OFS, 32'h0);
      check(32'(rd[tic_pkg::STAT_PSC1_LSB +: 3]), 32'h0);
      apb(1'b1, tic_pkg::CTRL_OFS, 32'h1);
      c = cnt1;
      repeat (7) pulse(0, 3, 6);
      check(32'(cnt1 - c), 32'h0);
      pulse(0, 3, 6);
      check(32'(cnt1 - c), 32'h1);
   endtask

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #(60000 * 100);
      num_errors++;
      finish_test();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      in1 = 1'b0;
      in2 = 1'b0;
      trg = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_lock();
      t_route();
      t_filter();
      t_psc();
      finish_test();
   end
endmodule
